// ### pcr_cfg_regs.sv
/*
 * Configuration header register bank of a PCI Ethernet controller: address map,
 * EEPROM-loaded words, command/status with error capture, decode enables.
 * Assumes config cycles, bus events and the EEPROM engine all run on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcr_cfg.svh"

module pcr_cfg_regs import pcr_pkg::*; (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Configuration cycles
    input  wire pcr_cfg_req_t cfgReq,
    output logic              cfgAck,
    output logic [31:0]       cfgRdata,
    // EEPROM autoload engine
    output logic              eeLoadReq,
    input  wire pcr_ee_word_t eeWord,
    input  wire logic         eeLoadDone,
    // PCI bus logic
    input  wire pcr_bus_evt_t busEvt,
    output logic              serrOut,
    output pcr_ctrl_t         ctrl
);

    pcr_state_t st_ff;
    pcr_state_t nxt_st;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] beMerge(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (oldV & ~m) | (newV & m);
    endfunction : beMerge

    logic [7:0]  wordAddr;
    logic        wrHit;
    logic        rdHit;
    logic [31:0] cmdStat;
    logic [31:0] rdMux;
    logic [31:0] wv;
    logic [31:0] clr;
    logic [31:0] mrg;

    assign wordAddr = {cfgReq.addr[7:2], 2'h0};
    assign wrHit    = cfgReq.sel & cfgReq.wr;
    assign rdHit    = cfgReq.sel & ~cfgReq.wr;

    // Fixed bits of status come from constants, never from state
    assign cmdStat = {st_ff.parErr, st_ff.sysErr, st_ff.mAbort, st_ff.tAbort,
                      1'h0, `PCR_DEVSEL_MED,
                      st_ff.dataPar, 1'h1, 2'h0, 1'h1,
                      11'h0, st_ff.sysErrEn, 1'h0, st_ff.parRespEn, 3'h0,
                      st_ff.masterEn, st_ff.memEn, st_ff.ioEn};

    // ****************************************
    // Read multiplexer
    // ****************************************
    always_comb begin
        if (wordAddr == `PCR_OFF_IDENT) begin
            rdMux = st_ff.ident;
        end else if (wordAddr == `PCR_OFF_CMDSTAT) begin
            rdMux = cmdStat;
        end else if (wordAddr == `PCR_OFF_CLASS) begin
            rdMux = `PCR_CLASS_VAL;
        end else if (wordAddr == `PCR_OFF_LATENCY) begin
            rdMux = {16'h0, st_ff.latLine};
        end else if (wordAddr == `PCR_OFF_IOBASE) begin
            rdMux = {st_ff.ioBase, 7'h0, `PCR_IOSPACE_BIT};
        end else if (wordAddr == `PCR_OFF_MEMBASE) begin
            rdMux = {st_ff.memBase, 10'h0};
        end else if (wordAddr == `PCR_OFF_CARDINFO) begin
            rdMux = st_ff.cardInfo;
        end else if (wordAddr == `PCR_OFF_SUBSYS) begin
            rdMux = st_ff.subsys;
        end else if (wordAddr == `PCR_OFF_ROMBASE) begin
            rdMux = {st_ff.romBase, 10'h0, st_ff.romEn};
        end else if (wordAddr == `PCR_OFF_CAPPTR) begin
            rdMux = {24'h0, `PCR_OFF_PMCAP};
        end else if (wordAddr == `PCR_OFF_INTR) begin
            rdMux = {st_ff.intTime, `PCR_INT_PIN, st_ff.intLine};
        end else if (wordAddr == `PCR_OFF_SCRATCH) begin
            rdMux = {16'h0, st_ff.scratch, 8'h0};
        end else if (wordAddr == `PCR_OFF_SIG) begin
            rdMux = `PCR_SIG_VAL;
        end else if (wordAddr == `PCR_OFF_PMCAP) begin
            rdMux = `PCR_PMCAP_VAL;
        end else if (wordAddr == `PCR_OFF_POWER_CONTROL_STATUS) begin
            rdMux = {30'h0, st_ff.pwrState};
        end else begin
            rdMux = 32'h0;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st       = st_ff;
        wv           = beMerge(32'h0, cfgReq.wdata, cfgReq.be);
        clr          = 32'h0;
        mrg          = 32'h0;
        nxt_st.ack   = cfgReq.sel;
        nxt_st.rdata = rdHit ? rdMux : st_ff.rdata;

        // Reload sequence starts at every reset release
        case (st_ff.ld)
            PCR_LD_REQ: begin
                nxt_st.ld = PCR_LD_WAIT;
            end
            PCR_LD_WAIT: begin
                if (eeWord.valid) begin
                    if (eeWord.idx == `PCR_EE_IDENT) begin
                        nxt_st.ident = eeWord.data;
                    end else if (eeWord.idx == `PCR_EE_CARDINFO) begin
                        nxt_st.cardInfo = eeWord.data;
                    end else if (eeWord.idx == `PCR_EE_SUBSYS) begin
                        nxt_st.subsys = eeWord.data;
                    end else begin
                        nxt_st.intTime = eeWord.data[15:0];
                    end
                end
                if (eeLoadDone) begin
                    nxt_st.ld = PCR_LD_DONE;
                end
            end
            default: begin
                nxt_st.ld = PCR_LD_DONE;
            end
        endcase

        // Identification, card-info, subsystem and signature take no writes
        if (wrHit) begin
            if (wordAddr == `PCR_OFF_CMDSTAT) begin
                nxt_st.ioEn      = cfgReq.be[0] ? cfgReq.wdata[0] : st_ff.ioEn;
                nxt_st.memEn     = cfgReq.be[0] ? cfgReq.wdata[1] : st_ff.memEn;
                nxt_st.masterEn  = cfgReq.be[0] ? cfgReq.wdata[2] : st_ff.masterEn;
                nxt_st.parRespEn = cfgReq.be[0] ? cfgReq.wdata[6] : st_ff.parRespEn;
                nxt_st.sysErrEn  = cfgReq.be[1] ? cfgReq.wdata[8] : st_ff.sysErrEn;
                clr              = wv;
            end else if (wordAddr == `PCR_OFF_LATENCY) begin
                // Merged word lands in mrg, then only the writable field is kept
                mrg            = beMerge({16'h0, st_ff.latLine}, cfgReq.wdata, cfgReq.be);
                nxt_st.latLine = mrg[15:0];
            end else if (wordAddr == `PCR_OFF_IOBASE) begin
                // Low byte holds the fixed space indicator, so that lane is dropped
                mrg           = beMerge({st_ff.ioBase, 8'h0}, cfgReq.wdata, cfgReq.be);
                nxt_st.ioBase = mrg[31:8];
            end else if (wordAddr == `PCR_OFF_MEMBASE) begin
                mrg            = beMerge({st_ff.memBase, 10'h0}, cfgReq.wdata, cfgReq.be);
                nxt_st.memBase = mrg[31:10];
            end else if (wordAddr == `PCR_OFF_ROMBASE) begin
                mrg            = beMerge({st_ff.romBase, 11'h0}, cfgReq.wdata, cfgReq.be);
                nxt_st.romBase = mrg[31:11];
                nxt_st.romEn   = cfgReq.be[0] ? cfgReq.wdata[0] : st_ff.romEn;
            end else if (wordAddr == `PCR_OFF_INTR) begin
                nxt_st.intLine = cfgReq.be[0] ? cfgReq.wdata[7:0] : st_ff.intLine;
            end else if (wordAddr == `PCR_OFF_SCRATCH) begin
                nxt_st.scratch = cfgReq.be[1] ? cfgReq.wdata[15:8] : st_ff.scratch;
            end else if (wordAddr == `PCR_OFF_POWER_CONTROL_STATUS) begin
                nxt_st.pwrState = cfgReq.be[0] ? cfgReq.wdata[1:0] : st_ff.pwrState;
            end
        end

        // Address parity reaches SERR only with both enables on
        nxt_st.serr = busEvt.addrParityErr & st_ff.sysErrEn & st_ff.parRespEn;

        // A new error event wins over a clear in the same cycle
        nxt_st.parErr  = busEvt.parityErr | busEvt.addrParityErr | (st_ff.parErr & ~clr[31]);
        nxt_st.sysErr  = st_ff.serr | (st_ff.sysErr & ~clr[30]);
        nxt_st.mAbort  = busEvt.masterAbort | (st_ff.mAbort & ~clr[29]);
        nxt_st.tAbort  = busEvt.targetAbort | (st_ff.tAbort & ~clr[28]);
        nxt_st.dataPar = (busEvt.perrSeen & busEvt.isMaster & st_ff.parRespEn)
                         | (st_ff.dataPar & ~clr[24]);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff    <= '0;
            st_ff.ld <= PCR_LD_REQ;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cfgAck             = st_ff.ack;
    assign cfgRdata           = st_ff.rdata;
    assign eeLoadReq          = (st_ff.ld == PCR_LD_REQ);
    assign serrOut            = st_ff.serr;
    assign ctrl.busMasterEn   = st_ff.masterEn;
    assign ctrl.memDecodeEn   = st_ff.memEn;
    assign ctrl.ioDecodeEn    = st_ff.ioEn;
    assign ctrl.parityRespEn  = st_ff.parRespEn;
    assign ctrl.ioBase        = st_ff.ioBase;
    assign ctrl.memBase       = st_ff.memBase;
    assign ctrl.latency       = st_ff.latLine[15:8];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ident_ro_a: assert property (wrHit && wordAddr == `PCR_OFF_IDENT && !eeWord.valid
        |=> $stable(st_ff.ident)) else $error("ident word changed by write");
    card_ro_a: assert property (wrHit && wordAddr == `PCR_OFF_CARDINFO && !eeWord.valid
        |=> $stable(st_ff.cardInfo)) else $error("card info changed by write");
    sig_read_a: assert property (rdHit && wordAddr == `PCR_OFF_SIG
        |=> cfgAck && cfgRdata == `PCR_SIG_VAL) else $error("signature wrong");
    fixed_bits_a: assert property (rdHit && wordAddr == `PCR_OFF_CMDSTAT
        |=> cfgRdata[26:25] == `PCR_DEVSEL_MED && cfgRdata[23] && cfgRdata[20]
        && cfgRdata[27] == 1'h0 && cfgRdata[22:21] == 2'h0 && cfgRdata[19:9] == 11'h0)
        else $error("fixed status bits wrong");
    parity_flag_a: assert property (busEvt.parityErr |=> st_ff.parErr)
        else $error("parity flag not set");
    serr_path_a: assert property (busEvt.addrParityErr && st_ff.sysErrEn && st_ff.parRespEn
        |=> serrOut ##1 st_ff.sysErr) else $error("SERR path broken");
    abort_flags_a: assert property (busEvt.masterAbort |=> st_ff.mAbort)
        else $error("master abort flag not set");
    tabort_flag_a: assert property (busEvt.targetAbort |=> st_ff.tAbort)
        else $error("target abort flag not set");
    dpr_cause_a: assert property ($rose(st_ff.dataPar)
        |-> $past(busEvt.perrSeen && busEvt.isMaster && st_ff.parRespEn))
        else $error("data parity flag without cause");
    w1c_clear_a: assert property (wrHit && wordAddr == `PCR_OFF_CMDSTAT && cfgReq.be[3]
        && cfgReq.wdata[31] && !busEvt.parityErr && !busEvt.addrParityErr |=> !st_ff.parErr)
        else $error("parity flag not cleared");
    no_parresp_a: assert property (!st_ff.parRespEn && !wrHit |=> !serrOut[*2])
        else $error("SERR with parity response off");
    master_gate_a: assert property (wrHit && wordAddr == `PCR_OFF_CMDSTAT && cfgReq.be[0]
        && !cfgReq.wdata[2] |=> !ctrl.busMasterEn) else $error("master enable stuck");
    reserved_rd_a: assert property (rdHit && wordAddr == 8'h18 |=> cfgRdata == 32'h0)
        else $error("reserved offset not zero");

    // Fixed fields of other words; a wrong constant misleads bus enumeration
    io_low_a: assert property (rdHit && wordAddr == `PCR_OFF_IOBASE
        |=> cfgRdata[7:0] == {7'h0, `PCR_IOSPACE_BIT})
        else $error("I/O base low byte wrong");
    mem_low_a: assert property (rdHit && wordAddr == `PCR_OFF_MEMBASE
        |=> cfgRdata[9:0] == 10'h0)
        else $error("memory base low bits not zero");
    pm_cap_a: assert property (rdHit && wordAddr == `PCR_OFF_PMCAP
        |=> cfgRdata == `PCR_PMCAP_VAL)
        else $error("power capability word wrong");
    cap_ptr_a: assert property (rdHit && wordAddr == `PCR_OFF_CAPPTR
        |=> cfgRdata == {24'h0, `PCR_OFF_PMCAP})
        else $error("capability pointer wrong");
    lat_rsvd_a: assert property (rdHit && wordAddr == `PCR_OFF_LATENCY
        |=> cfgRdata[31:16] == 16'h0)
        else $error("latency word upper half not zero");
    power_control_status_rsvd_a: assert property (rdHit && wordAddr == `PCR_OFF_POWER_CONTROL_STATUS
        |=> cfgRdata[31:2] == 30'h0)
        else $error("power control reserved bits not zero");
    scratch_rd_a: assert property (rdHit && wordAddr == `PCR_OFF_SCRATCH
        |=> cfgRdata[31:16] == 16'h0 && cfgRdata[7:0] == 8'h0)
        else $error("driver space reserved bits not zero");

    // Command bits reach the decoders one cycle after the write
    io_decode_a: assert property (wrHit && wordAddr == `PCR_OFF_CMDSTAT && cfgReq.be[0]
        |=> ctrl.ioDecodeEn == $past(cfgReq.wdata[0]))
        else $error("I/O decode enable wrong");
    mem_decode_a: assert property (wrHit && wordAddr == `PCR_OFF_CMDSTAT && cfgReq.be[0]
        |=> ctrl.memDecodeEn == $past(cfgReq.wdata[1]))
        else $error("memory decode enable wrong");

    // Error capture
    addr_parity_a: assert property (busEvt.addrParityErr |=> st_ff.parErr)
        else $error("address parity not flagged");
    serr_flag_a: assert property (serrOut |=> st_ff.sysErr)
        else $error("system error flag not set");
    dpr_gate_a: assert property (!st_ff.parRespEn && !st_ff.dataPar |=> !st_ff.dataPar)
        else $error("data parity flag with response off");

    // Handshake: one acknowledge per request, read data held between reads
    ack_set_a: assert property (cfgReq.sel |=> cfgAck)
        else $error("request not acknowledged");
    ack_clr_a: assert property (!cfgReq.sel |=> !cfgAck)
        else $error("acknowledge without request");
    rdata_hold_a: assert property (!rdHit |=> $stable(cfgRdata))
        else $error("read data moved without a read");

    // Reload from the serial memory after each reset release
    ld_wait_a: assert property (eeLoadReq |=> !eeLoadReq)
        else $error("load request longer than one cycle");
    ident_load_a: assert property (st_ff.ld == PCR_LD_WAIT && eeWord.valid
        && eeWord.idx == `PCR_EE_IDENT |=> st_ff.ident == $past(eeWord.data))
        else $error("identification word not loaded");
    card_load_a: assert property (st_ff.ld == PCR_LD_WAIT && eeWord.valid
        && eeWord.idx == `PCR_EE_CARDINFO |=> st_ff.cardInfo == $past(eeWord.data))
        else $error("card info word not loaded");
    ident_hold_a: assert property (st_ff.ld == PCR_LD_DONE |=> $stable(st_ff.ident))
        else $error("identification word changed after load");

endmodule : pcr_cfg_regs
`default_nettype wire

// ### pcr_cfg.svh
/*
 * Constants of the configuration header register bank: offsets, field positions,
 * reset values and fixed codes.
 * Assumes inclusion by bare name from the design module and the bench.
 */
// Contract
// - Header maps I/O, memory, power-capability words
// - EEPROM-sourced words reload after reset release
// - Identification word read-only, product/maker halves
// - Card-information word ignores configuration writes
// - Driver-space word: only bits 15-8 writable
// - Signature word hard-wired, read-only
// - Parity flag set on any parity error
// - System-error flag set when SERR driven
// - Master-abort flag set on master abort
// - Target-abort flag set on target abort
// - Device-select timing field reads 01
// - Data-parity flag: master, PERR, response enabled
// - Fast back-to-back flag reads one
// - Capabilities flag reads one
// - System-error enable drives SERR on address parity
// - Command/status resets to 0290 0000
// - Parity response disabled ignores parity errors; the parity flag (bit 31) is still set
// - Command bit 2 gates bus mastering
// - Command bit 1 gates memory decoding
// - Command bit 0 gates I/O decoding
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// ****************************************
// Offsets (byte addresses)
// ****************************************
`define PCR_OFF_IDENT    8'h00
`define PCR_OFF_CMDSTAT  8'h04
`define PCR_OFF_CLASS    8'h08
`define PCR_OFF_LATENCY  8'h0c
`define PCR_OFF_IOBASE   8'h10
`define PCR_OFF_MEMBASE  8'h14
`define PCR_OFF_CARDINFO 8'h28
`define PCR_OFF_SUBSYS   8'h2c
`define PCR_OFF_ROMBASE  8'h30
`define PCR_OFF_CAPPTR   8'h34
`define PCR_OFF_INTR     8'h3c
`define PCR_OFF_SCRATCH  8'h40
`define PCR_OFF_SIG      8'h80
`define PCR_OFF_PMCAP    8'hc0
`define PCR_OFF_POWER_CONTROL_STATUS    8'hc4

// ****************************************
// Fixed values
// ****************************************
`define PCR_CMDSTAT_RST  32'h0290_0000
`define PCR_CLASS_VAL    32'h0200_0011
`define PCR_SIG_VAL      32'h0000_5a5a
`define PCR_PMCAP_VAL    32'h0000_0001
`define PCR_DEVSEL_MED   2'h1
`define PCR_IOSPACE_BIT  1'h1
`define PCR_INT_PIN      8'h01

// ****************************************
// EEPROM word selectors
// ****************************************
`define PCR_EE_IDENT     2'h0
`define PCR_EE_CARDINFO  2'h1
`define PCR_EE_SUBSYS    2'h2
`define PCR_EE_INTTIME   2'h3

`endif

// ### pcr_pkg.sv
/*
 * Types of the configuration header register bank.
 * Assumes pcr_cfg.svh sits in the same folder.
 */
package pcr_pkg;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcr_cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  idx;
        logic [31:0] data;
    } pcr_ee_word_t;

    typedef struct packed {
        logic parityErr;
        logic addrParityErr;
        logic masterAbort;
        logic targetAbort;
        logic perrSeen;
        logic isMaster;
    } pcr_bus_evt_t;

    typedef struct packed {
        logic        busMasterEn;
        logic        memDecodeEn;
        logic        ioDecodeEn;
        logic        parityRespEn;
        logic [23:0] ioBase;
        logic [21:0] memBase;
        logic [7:0]  latency;
    } pcr_ctrl_t;

    typedef enum logic [2:0] {
        PCR_LD_REQ  = 3'h1,
        PCR_LD_WAIT = 3'h2,
        PCR_LD_DONE = 3'h4
    } pcr_load_t;

    typedef struct packed {
        pcr_load_t   ld;
        logic        ack;
        logic [31:0] rdata;
        logic        serr;
        logic [31:0] ident;
        logic [31:0] cardInfo;
        logic [31:0] subsys;
        logic [15:0] intTime;
        logic        sysErrEn;
        logic        parRespEn;
        logic        masterEn;
        logic        memEn;
        logic        ioEn;
        logic        parErr;
        logic        sysErr;
        logic        mAbort;
        logic        tAbort;
        logic        dataPar;
        logic [15:0] latLine;
        logic [23:0] ioBase;
        logic [21:0] memBase;
        logic [20:0] romBase;
        logic        romEn;
        logic [7:0]  intLine;
        logic [7:0]  scratch;
        logic [1:0]  pwrState;
    } pcr_state_t;

endpackage : pcr_pkg

// ### pcr_ee_model.sv
/*
 * Serial EEPROM autoload engine model: answers each load request with four words
 * (identification, card information, subsystem, interrupt timing) and a done pulse.
 * Assumes the bank raises its load request once after every reset release.
 */
`timescale 1ns/1ps
`default_nettype none

module pcr_ee_model import pcr_pkg::*; #(
    parameter int GAP = 3
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Image held in the serial memory
    input  wire logic [31:0] identImg,
    input  wire logic [31:0] cardImg,
    // Load handshake
    input  wire logic        eeLoadReq,
    output pcr_ee_word_t     eeWord,
    output logic             eeLoadDone
);
    int step;

    // ****************************************
    // Word delivery
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step       <= 0;
            eeWord     <= '0;
            eeLoadDone <= 1'b0;
        end else begin
            if (step > GAP && step <= GAP + 4) begin
                eeWord.valid <= 1'b1;
                eeWord.idx   <= 2'(step - GAP - 1);
                case (step - GAP)
                    1: eeWord.data <= identImg;
                    2: eeWord.data <= cardImg;
                    3: eeWord.data <= ~identImg;
                    default: eeWord.data <= {16'h0, cardImg[31:16]};
                endcase
            end else begin
                // Data is meaningless between strobes, so keep it moving
                eeWord.valid <= 1'b0;
                eeWord.data  <= ~eeWord.data;
            end
            eeLoadDone <= (step == GAP + 5);
            if (eeLoadReq) step <= 1;
            else if (step == GAP + 5) step <= 0;
            else if (step != 0) step <= step + 1;
        end
    end
endmodule : pcr_ee_model

`default_nettype wire

// ### pci_config_header_regs_bench.sv
/*
 * Self-checking bench of the configuration header register bank.
 * Assumes the bank, its package and header, and the EEPROM model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcr_cfg.svh"

module pci_config_header_regs_bench import pcr_pkg::*;;
    logic         core_clk = 1'b0;
    logic         rst      = 1'b1;
    pcr_cfg_req_t cfgReq   = '0;
    pcr_bus_evt_t busEvt   = '0;
    logic         cfgAck;
    logic [31:0]  cfgRdata;
    logic         eeLoadReq;
    pcr_ee_word_t eeWord;
    logic         eeLoadDone;
    logic         serrOut;
    pcr_ctrl_t    ctrl;
    logic [31:0]  identImg = 32'h1357_2468;  // Arbitrary image
    logic [31:0]  cardImg  = 32'h0000_0a80;
    logic [31:0]  rd;
    logic [31:0]  w;
    int           fails      = 0;
    int           n_compared = 0;
    pcr_bus_evt_t evTab [7] = '{6'h20, 6'h08, 6'h04, 6'h03, 6'h03, 6'h10, 6'h10};
    logic [31:0]  cmdTab [7] = '{0, 0, 0, 32'h40, 0, 32'h140, 32'h40};
    logic [31:0]  flagTab [7] = '{32'h8000_0000, 32'h2000_0000, 32'h1000_0000,
                                  32'h0100_0000, 0, 32'hc000_0000, 32'h8000_0000};
    logic [31:0]  serrTab [7] = '{0, 0, 0, 0, 0, 1, 0};

    always #50 core_clk = ~core_clk;

    pcr_cfg_regs i_dut (.core_clk(core_clk), .rst(rst), .cfgReq(cfgReq), .cfgAck(cfgAck),
        .cfgRdata(cfgRdata), .eeLoadReq(eeLoadReq), .eeWord(eeWord),
        .eeLoadDone(eeLoadDone), .busEvt(busEvt), .serrOut(serrOut), .ctrl(ctrl));

    pcr_ee_model i_ee (.core_clk(core_clk), .rst(rst), .identImg(identImg),
        .cardImg(cardImg), .eeLoadReq(eeLoadReq), .eeWord(eeWord),
        .eeLoadDone(eeLoadDone));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cfg(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                       input logic [31:0] wd);
        @(posedge core_clk);
        cfgReq <= '{1'b1, wr, addr, be, wd};
        @(posedge core_clk);
        cfgReq.sel <= 1'b0;
        #1;
        check({31'h0, cfgAck}, 32'h1);
        rd = cfgRdata;
    endtask : cfg

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        cfg(1'b0, addr, 4'h0, 32'h0);
        check(rd, exp);
    endtask : rdchk

    task automatic do_reset;
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 40 && eeLoadDone !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        check({31'h0, eeLoadDone}, 32'h1);
    endtask : do_reset

    task automatic close_out;
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        close_out();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        w = $urandom(10339);
        do_reset();
        rdchk(8'h04, 32'h0290_0000);
        rdchk(8'h00, identImg);
        cfg(1'b1, 8'h00, 4'hf, ~identImg);
        rdchk(8'h00, identImg);
        cfg(1'b1, 8'h28, 4'hf, $urandom);
        rdchk(8'h28, cardImg);
        cfg(1'b1, 8'h80, 4'hf, $urandom);
        rdchk(8'h80, `PCR_SIG_VAL);
        rdchk(8'hc0, `PCR_PMCAP_VAL);
        cfg(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
        check({8'h0, ctrl.ioBase}, 32'h00ff_ffff);
        rdchk(8'h10, 32'hffff_ff01);
        cfg(1'b1, 8'h14, 4'hf, 32'hffff_ffff);
        check({10'h0, ctrl.memBase}, 32'h003f_ffff);
        rdchk(8'h14, 32'hffff_fc00);
        w = $urandom;
        cfg(1'b1, 8'h0c, 4'hf, w);
        check({24'h0, ctrl.latency}, {24'h0, w[15:8]});
        rdchk(8'h0c, {16'h0, w[15:0]});
        cfg(1'b1, 8'h30, 4'hf, 32'hffff_ffff);
        rdchk(8'h30, 32'hffff_f801);
        cfg(1'b1, 8'hc4, 4'hf, 32'hffff_ffff);
        rdchk(8'hc4, 32'h0000_0003);
        rdchk(8'h08, `PCR_CLASS_VAL);
        rdchk(8'h34, 32'h0000_00c0);
        foreach (cmdTab[i]) begin
            // Reserved offsets: 18h-24h, then a few above the driver-space word
            w = 32'h18 + 32'(i * 4) + (i > 3 ? 32'h40 : 32'h0);
            cfg(1'b1, w[7:0], 4'hf, $urandom);
            rdchk(w[7:0], 32'h0);
            w = $urandom;
            cfg(1'b1, 8'h40, 4'hf, w);
            rdchk(8'h40, {16'h0, w[15:8], 8'h0});
            cfg(1'b1, 8'h40, 4'hd, ~w);
            rdchk(8'h40, {16'h0, w[15:8], 8'h0});
            w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            cfg(1'b1, 8'h04, 4'hf, w);
            check({28'h0, ctrl.busMasterEn, ctrl.memDecodeEn, ctrl.ioDecodeEn,
                   ctrl.parityRespEn}, {28'h0, w[2], w[1], w[0], w[6]});
            rdchk(8'h04, 32'h0290_0000 | (w & 32'h0000_0147));
        end
        foreach (evTab[i]) begin
            cfg(1'b1, 8'h04, 4'hf, cmdTab[i]);
            @(posedge core_clk);
            busEvt <= evTab[i];
            @(posedge core_clk);
            busEvt <= '0;
            #1;
            // SERR request stands for one cycle, right after the event edge
            check({31'h0, serrOut}, serrTab[i]);
            rdchk(8'h04, 32'h0290_0000 | cmdTab[i] | flagTab[i]);
            cfg(1'b1, 8'h04, 4'hf, cmdTab[i]);
            rdchk(8'h04, 32'h0290_0000 | cmdTab[i] | flagTab[i]);
            cfg(1'b1, 8'h04, 4'h7, cmdTab[i] | 32'hf100_0000);
            rdchk(8'h04, 32'h0290_0000 | cmdTab[i] | flagTab[i]);
            cfg(1'b1, 8'h04, 4'hf, cmdTab[i] | 32'hf100_0000);
            rdchk(8'h04, 32'h0290_0000 | cmdTab[i]);
        end
        identImg = $urandom;
        cardImg  = $urandom;
        do_reset();
        rdchk(8'h00, identImg);
        rdchk(8'h28, cardImg);
        rdchk(8'h2c, ~identImg);
        rdchk(8'h3c, {cardImg[31:16], `PCR_INT_PIN, 8'h00});
        rdchk(8'h04, 32'h0290_0000);
        close_out();
    end
endmodule : pci_config_header_regs_bench

`default_nettype wire
